// ===== host_link_model.sv
// Host link model driving select, serial clock, data and pause pins
`timescale 1ns/10ps
module host_link_model (
  input  wire logic                  sys_clk,
  output serial_hold_pkg::spi_pins_s pins
);
  // Half link period of 100 ns in system clocks
  localparam int HALF = 4;
  initial pins = 4'hB;
  task automatic idle();
    repeat (HALF) @(posedge sys_clk);
  endtask : idle
  // Pause is lifted before select falls, so no pause is re-entered
  task automatic select();
    pins.hold_n <= 1'h1;
    idle();
    pins.cs_n <= 1'h0;
    idle();
  endtask : select
  // A released data line shows the inverse of its last bit
  task automatic deselect();
    pins.cs_n <= 1'h1;
    pins.si   <= ~pins.si;
    idle();
  endtask : deselect
  // Select is never touched here, so it stays low through a pause
  task automatic set_hold(input logic v);
    pins.hold_n <= v;
    idle();
  endtask : set_hold
  task automatic set_sck(input logic v);
    pins.sck <= v;
    idle();
  endtask : set_sck
  // MSB first; data moves only while the clock is low
  task automatic send_bits(input logic [7:0] b, input int hi, input int lo);
    for (int i = hi; i >= lo; i--)
    begin
      pins.si <= b[i];
      set_sck(1'h0);
      set_sck(1'h1);
    end
    set_sck(1'h0);
  endtask : send_bits
endmodule : host_link_model

// ===== serial_hold_and_sector_map.sv
// Serial link front end with pause control, page cache and sector map
`timescale 1ns/10ps
module serial_hold_and_sector_map #(
  parameter int PAGE_BYTES = serial_hold_pkg::PAGE_BYTES
) (
  input  wire logic                          sys_clk,
  input  wire logic                          reset_n,
  input  wire logic                          clk_en,
  input  wire serial_hold_pkg::spi_pins_s    pins,
  output logic                               so_out,
  output logic                               so_oe,
  input  wire logic [7:0]                    config_bits,
  input  wire logic                          tx_enable,
  input  wire logic [7:0]                    tx_byte,
  output logic                               rx_valid,
  output logic [7:0]                         rx_byte,
  output logic                               paused,
  input  wire logic                          cache_load,
  input  wire logic [$clog2(PAGE_BYTES)-1:0] cache_ptr,
  input  wire logic [$clog2(PAGE_BYTES)-1:0] commit_idx,
  input  wire logic [7:0]                    array_old,
  output logic [7:0]                         commit_data,
  output logic [7:0]                         erase_data,
  input  wire logic                          accel_req,
  output logic                               program_accel_func,
  input  wire logic [23:0]                   op_addr,
  input  wire serial_hold_pkg::erase_kind_e  erase_kind,
  output logic [6:0]                         sector_idx,
  output logic                               sub_hit,
  output logic [4:0]                         sub_idx,
  output logic                               erase_ok,
  output logic [23:0]                        erase_first,
  output logic [23:0]                        erase_last
);
  localparam int PW = $clog2(PAGE_BYTES);

  // Pin inputs cross in through two flops; stage one is read by stage two only
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic       sck_prev_q;
  logic       hold_prev_q;
  serial_hold_pkg::spi_pins_s pin_s;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync1_q <= 4'hB;
      sync2_q <= 4'hB;
    end
    else if (clk_en)
    begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
    end
  end

  assign pin_s = serial_hold_pkg::spi_pins_s'(sync2_q);

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sck_prev_q  <= 1'b0;
      hold_prev_q <= 1'b1;
    end
    else if (clk_en)
    begin
      sck_prev_q  <= pin_s.sck;
      hold_prev_q <= pin_s.hold_n;
    end
  end

  wire quad_mode = config_bits[serial_hold_pkg::CFG_QUAD_BIT];
  wire param_sector_top_sel =
    config_bits[serial_hold_pkg::CFG_PARAM_TOP];
  wire sck_rise  = pin_s.sck & ~sck_prev_q;
  wire sck_fall  = ~pin_s.sck & sck_prev_q;
  wire hold_edge = pin_s.hold_n ^ hold_prev_q;
  wire cs_idle   = pin_s.cs_n;

  // Pause state follows the pin only at a pin edge with clock low, or at a
  // clock fall; a change made while the clock is high waits for the fall.
  logic paused_q;
  logic paused_d;
  wire  pause_want = ~pin_s.hold_n & ~quad_mode;
  wire  pause_move = (hold_edge & ~pin_s.sck) | sck_fall;

  always_comb
  begin
    paused_d = paused_q;
    if (cs_idle | quad_mode)
      paused_d = 1'b0;
    else if (pause_move)
      paused_d = pause_want;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      paused_q <= 1'b0;
    else if (clk_en)
      paused_q <= paused_d;
  end

  assign paused = paused_q;

  // Serial engine: edges count only while selected and not paused
  logic [2:0] bit_cnt_q;
  logic [7:0] shift_in_q;
  logic [7:0] shift_out_q;
  logic       so_q;
  logic       rx_valid_q;
  logic [7:0] rx_byte_q;
  wire        live     = ~cs_idle & ~paused_q;
  wire        take_bit = live & sck_rise;
  wire        put_bit  = live & sck_fall;
  wire        byte_end = take_bit & (bit_cnt_q == serial_hold_pkg::BIT_CNT_LAST);

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bit_cnt_q   <= serial_hold_pkg::BIT_CNT_RST;
      shift_in_q  <= 8'h00;
      shift_out_q <= 8'h00;
      so_q        <= 1'b0;
      rx_valid_q  <= 1'b0;
      rx_byte_q   <= 8'h00;
    end
    else if (clk_en)
    begin
      rx_valid_q <= byte_end;
      if (cs_idle)
      begin
        bit_cnt_q   <= serial_hold_pkg::BIT_CNT_RST;
        shift_in_q  <= 8'h00;
        shift_out_q <= tx_byte;
      end
      else
      begin
        if (take_bit)
        begin
          bit_cnt_q  <= bit_cnt_q + 3'h1;
          shift_in_q <= {shift_in_q[6:0], pin_s.si};
        end
        if (byte_end)
        begin
          rx_byte_q   <= {shift_in_q[6:0], pin_s.si};
          shift_out_q <= tx_byte;
        end
        else if (put_bit)
        begin
          so_q        <= shift_out_q[7];
          shift_out_q <= {shift_out_q[6:0], 1'b0};
        end
      end
    end
  end

  assign so_out   = so_q;
  assign so_oe    = live & tx_enable;
  assign rx_valid = rx_valid_q;
  assign rx_byte  = rx_byte_q;

  // Page cache; the commit side runs off the internal clock and ignores
  // pause, so a program already under way completes.
  logic [7:0] cache_mem [PAGE_BYTES];
  logic [7:0] commit_q;

  always_ff @(posedge sys_clk)
  begin
    if (clk_en && rx_valid_q && cache_load)
      cache_mem[cache_ptr] <= rx_byte_q;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      commit_q <= serial_hold_pkg::ERASED_BYTE;
    else if (clk_en)
      commit_q <= array_old & cache_mem[commit_idx];
  end

  assign commit_data = commit_q;
  assign erase_data  = serial_hold_pkg::ERASED_BYTE;
  assign program_accel_func = accel_req & ~quad_mode;

  // Sector map decode
  wire [5:0] pair_idx  = op_addr[22:17];
  wire [5:0] sub_pair  = param_sector_top_sel ?
                         serial_hold_pkg::SUB_TOP_PAIR :
                         serial_hold_pkg::SUB_BOT_PAIR;
  wire       in_array  = op_addr <= serial_hold_pkg::ARRAY_LAST;
  wire       sub_in    = in_array & (pair_idx == sub_pair);
  wire [23:0] sec_base = {op_addr[23:16], 16'h0000};
  wire [23:0] sub_base = {op_addr[23:12], 12'h000};
  wire [23:0] pair_base = {op_addr[23:13], 13'h0000};

  logic [23:0] first_d;
  logic [23:0] last_d;
  logic        ok_d;

  always_comb
  begin
    first_d = sec_base;
    last_d  = sec_base + serial_hold_pkg::SECTOR_LAST_OFS;
    ok_d    = in_array;
    case (erase_kind)
      serial_hold_pkg::ERASE_4K:
      begin
        first_d = sub_base;
        last_d  = sub_base + serial_hold_pkg::SUB_LAST_OFS;
        ok_d    = sub_in;
      end
      serial_hold_pkg::ERASE_8K:
      begin
        first_d = pair_base;
        last_d  = pair_base + serial_hold_pkg::PAIR_LAST_OFS;
        ok_d    = sub_in;
      end
      serial_hold_pkg::ERASE_64K: ok_d = in_array;
      serial_hold_pkg::ERASE_WHOLE:
      begin
        first_d = serial_hold_pkg::ARRAY_FIRST;
        last_d  = serial_hold_pkg::ARRAY_LAST;
        ok_d    = 1'b1;
      end
      default: ok_d = 1'b0;
    endcase
  end

  logic [6:0]  sector_q;
  logic        sub_hit_q;
  logic [4:0]  sub_idx_q;
  logic        ok_q;
  logic [23:0] first_q;
  logic [23:0] last_q;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sector_q  <= 7'h00;
      sub_hit_q <= 1'b0;
      sub_idx_q <= 5'h00;
      ok_q      <= 1'b0;
      first_q   <= 24'h00_0000;
      last_q    <= 24'h00_0000;
    end
    else if (clk_en)
    begin
      sector_q  <= op_addr[22:16];
      sub_hit_q <= sub_in;
      sub_idx_q <= op_addr[16:12];
      ok_q      <= ok_d;
      first_q   <= first_d;
      last_q    <= last_d;
    end
  end

  assign sector_idx  = sector_q;
  assign sub_hit     = sub_hit_q;
  assign sub_idx     = sub_idx_q;
  assign erase_ok    = ok_q;
  assign erase_first = first_q;
  assign erase_last  = last_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence s_armed;
    clk_en && !cs_idle && !quad_mode;
  endsequence
  sequence s_fall_low;
    s_armed ##0 hold_edge && !pin_s.hold_n && !pin_s.sck && !paused_q;
  endsequence
  sequence s_fall_high;
    s_armed ##0 hold_edge && !pin_s.hold_n && pin_s.sck && !sck_fall
      && !paused_q;
  endsequence
  sequence s_rise_low;
    s_armed ##0 hold_edge && pin_s.hold_n && !pin_s.sck && paused_q;
  endsequence
  sequence s_rise_high;
    s_armed ##0 hold_edge && pin_s.hold_n && pin_s.sck && !sck_fall
      && paused_q;
  endsequence

  AST_ENTER_LOW: assert property (s_fall_low |=> paused_q)
    else $error("pause not entered with clock low");
  AST_ENTER_DEFER: assert property (s_fall_high |=> !paused_q)
    else $error("pause entered while clock high");
  AST_EXIT_LOW: assert property (s_rise_low |=> !paused_q)
    else $error("pause not left with clock low");
  AST_EXIT_DEFER: assert property (s_rise_high |=> paused_q)
    else $error("pause left while clock high");
  AST_SO_RELEASED: assert property (paused_q |-> !so_oe)
    else $error("output driven while paused");
  AST_CS_RESET: assert property (clk_en && cs_idle |=>
    !paused_q && bit_cnt_q == serial_hold_pkg::BIT_CNT_RST)
    else $error("select high did not reset serial logic");
  AST_QUAD_NO_PAUSE: assert property (clk_en && quad_mode |=> !paused_q)
    else $error("pause active in four-lane mode");
  AST_ACCEL_OFF: assert property (quad_mode |-> !program_accel_func)
    else $error("accelerated programming in four-lane mode");
  AST_FREEZE: assert property (paused_q && !cs_idle |=>
    $stable(bit_cnt_q) && $stable(shift_in_q))
    else $error("serial state moved while paused");
  AST_ONLY_CLEARS: assert property (clk_en |=>
    (commit_data & ~$past(array_old)) == 8'h00)
    else $error("program would set a bit");
  AST_SUB_MAP: assert property (clk_en && sub_in |=>
    sub_hit && (param_sector_top_sel ? $past(op_addr) >=
    serial_hold_pkg::SUB_TOP_FIRST : $past(op_addr) <=
    serial_hold_pkg::SUB_BOT_LAST))
    else $error("sub-sector placed wrongly");
endmodule : serial_hold_and_sector_map

// ===== serial_hold_and_sector_map_tb.sv
// Self-checking bench for the pause control and sector map block
`timescale 1ns/10ps
module serial_hold_and_sector_map_tb;
  logic                         sys_clk;
  logic                         reset_n;
  logic                         clk_en;
  logic                         tx_enable;
  logic [7:0]                   tx_byte;
  serial_hold_pkg::spi_pins_s   pins;
  logic                         so_out;
  logic                         so_oe;
  logic [7:0]                   config_bits;
  logic                         rx_valid;
  logic [7:0]                   rx_byte;
  logic [7:0]                   last_rx;
  logic                         paused;
  logic                         cache_load;
  logic [7:0]                   cache_ptr;
  logic [7:0]                   commit_idx;
  logic [7:0]                   array_old;
  logic [7:0]                   commit_data;
  logic [7:0]                   erase_data;
  logic                         accel_req;
  logic                         accel_on;
  logic [23:0]                  op_addr;
  serial_hold_pkg::erase_kind_e erase_kind;
  logic [6:0]                   sector_idx;
  logic                         sub_hit;
  logic [4:0]                   sub_idx;
  logic                         erase_ok;
  logic [23:0]                  erase_first;
  logic [23:0]                  erase_last;
  int                           n_errors;
  int                           n_compared;
  int                           n_rx;

  host_link_model host (.sys_clk(sys_clk), .pins(pins));
  serial_hold_and_sector_map DUT (
    .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en), .pins(pins),
    .so_out(so_out), .so_oe(so_oe), .config_bits(config_bits),
    .tx_enable(tx_enable), .tx_byte(tx_byte), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .paused(paused), .cache_load(cache_load),
    .cache_ptr(cache_ptr), .commit_idx(commit_idx), .array_old(array_old),
    .commit_data(commit_data), .erase_data(erase_data),
    .accel_req(accel_req), .program_accel_func(accel_on),
    .op_addr(op_addr), .erase_kind(erase_kind), .sector_idx(sector_idx),
    .sub_hit(sub_hit), .sub_idx(sub_idx), .erase_ok(erase_ok),
    .erase_first(erase_first), .erase_last(erase_last));

  initial
  begin
    sys_clk = 1'h0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
    if (rx_valid === 1'h1)
    begin
      n_rx++;
      last_rx = rx_byte;
    end

  task automatic check(input string what, input logic [23:0] got,
                       input logic [23:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic t_decode();
    logic [23:0] adr [7] = '{24'h00_0000, 24'h01_FFFF, 24'h02_0000,
                             24'h7D_FFFF, 24'h7E_0000, 24'h7F_FFFF,
                             24'h80_0000};
    logic [23:0] a;
    logic [23:0] span;
    logic        hit;
    for (int c = 0; c < 2; c++)
      for (int k = 0; k < 4; k++)
        foreach (adr[i])
        begin
          a = adr[i];
          config_bits <= {5'h0, c[0], 2'h0};
          op_addr <= a;
          erase_kind <= serial_hold_pkg::erase_kind_e'(k);
          repeat (2) @(posedge sys_clk);
          hit = (a[23:17] == (c ? 7'h3F : 7'h00));
          span = k == 0 ? 24'h00_0FFF : k == 1 ? 24'h00_1FFF :
                 k == 2 ? 24'h00_FFFF : 24'h7F_FFFF;
          check("erase_ok", 24'(erase_ok),
                24'(k == 3 ? 1'b1 : k < 2 ? hit : !a[23]));
          if (!a[23])
          begin
            check("sector_idx", 24'(sector_idx), 24'(a[22:16]));
            check("sub_hit", 24'(sub_hit), 24'(hit));
            if (hit)
              check("sub_idx", 24'(sub_idx), 24'(a[16:12]));
          end
          if (k < 2 ? hit : !a[23])
          begin
            check("erase_first", erase_first, a & ~span);
            check("erase_last", erase_last, a | span);
          end
        end
    // Enable low must hold the decode outputs where they were
    clk_en <= 1'h0;
    op_addr <= 24'h12_0000;
    repeat (3) @(posedge sys_clk);
    check("frozen_sector", 24'(sector_idx), 24'h00);
    clk_en <= 1'h1;
    repeat (2) @(posedge sys_clk);
    check("sector_idx", 24'(sector_idx), 24'h12);
    config_bits <= 8'h00;
    $display("sector map test done");
  endtask : t_decode

  task automatic t_cache();
    tx_byte <= 8'h02;
    host.select();
    cache_load <= 1'h1;
    cache_ptr <= 8'h05;
    host.send_bits(8'h3C, 7, 1);
    check("so_out", 24'(so_out), 24'h1);
    host.send_bits(8'h3C, 0, 0);
    check("so_out", 24'(so_out), 24'h0);
    cache_load <= 1'h0;
    commit_idx <= 8'h05;
    array_old <= 8'hF0;
    repeat (2) @(posedge sys_clk);
    check("rx_byte", 24'(last_rx), 24'h3C);
    check("commit_data", 24'(commit_data), 24'h30);
    check("erase_data", 24'(erase_data), 24'hFF);
    tx_enable <= 1'h0;
    @(posedge sys_clk);
    check("so_oe", 24'(so_oe), 24'h0);
    tx_enable <= 1'h1;
    host.deselect();
    $display("page cache test done");
  endtask : t_cache

  task automatic t_pause_low();
    int n0;
    host.select();
    n0 = n_rx;
    host.send_bits(8'hA5, 7, 4);
    host.set_hold(1'h0);
    check("paused", 24'(paused), 24'h1);
    check("so_oe", 24'(so_oe), 24'h0);
    host.send_bits(8'h0F, 7, 6);
    array_old <= 8'hFF;
    repeat (2) @(posedge sys_clk);
    check("commit_data", 24'(commit_data), 24'h3C);
    host.set_hold(1'h1);
    check("paused", 24'(paused), 24'h0);
    check("so_oe", 24'(so_oe), 24'h1);
    host.send_bits(8'hA5, 3, 0);
    repeat (4) @(posedge sys_clk);
    check("rx_count", 24'(n_rx - n0), 24'h1);
    check("rx_byte", 24'(last_rx), 24'hA5);
    host.deselect();
    $display("pause with clock low done");
  endtask : t_pause_low

  task automatic t_pause_high();
    host.select();
    host.set_sck(1'h1);
    host.set_hold(1'h0);
    host.idle();
    check("paused", 24'(paused), 24'h0);
    host.set_sck(1'h0);
    check("paused", 24'(paused), 24'h1);
    host.set_sck(1'h1);
    host.set_hold(1'h1);
    host.idle();
    check("paused", 24'(paused), 24'h1);
    host.set_sck(1'h0);
    check("paused", 24'(paused), 24'h0);
    host.deselect();
    $display("pause with clock high done");
  endtask : t_pause_high

  task automatic t_deselect();
    int n0;
    host.select();
    host.send_bits(8'hFF, 7, 5);
    host.set_hold(1'h0);
    host.deselect();
    check("paused", 24'(paused), 24'h0);
    n0 = n_rx;
    host.select();
    host.send_bits(8'h5A, 7, 0);
    repeat (4) @(posedge sys_clk);
    check("rx_count", 24'(n_rx - n0), 24'h1);
    check("rx_byte", 24'(last_rx), 24'h5A);
    host.deselect();
    $display("deselect during pause done");
  endtask : t_deselect

  task automatic t_quad();
    config_bits <= 8'h02;
    accel_req <= 1'h1;
    host.select();
    host.set_hold(1'h0);
    host.idle();
    check("paused", 24'(paused), 24'h0);
    check("accel", 24'(accel_on), 24'h0);
    host.set_hold(1'h1);
    host.deselect();
    config_bits <= 8'h00;
    repeat (2) @(posedge sys_clk);
    check("accel", 24'(accel_on), 24'h1);
    accel_req <= 1'h0;
    $display("four-lane test done");
  endtask : t_quad

  initial
  begin
    reset_n = 1'h0;
    clk_en = 1'h1;
    tx_enable = 1'h1;
    tx_byte = 8'h00;
    config_bits = 8'h00;
    cache_load = 1'h0;
    cache_ptr = 8'h00;
    commit_idx = 8'h00;
    array_old = 8'h00;
    accel_req = 1'h0;
    op_addr = 24'h00_0000;
    erase_kind = serial_hold_pkg::ERASE_4K;
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'h1;
    repeat (3) @(posedge sys_clk);
    t_decode();
    t_cache();
    t_pause_low();
    t_pause_high();
    t_deselect();
    t_quad();
    print_verdict();
  end

  // About 530 clocks of tests; cut off at about fifteen times that
  initial
  begin
    #200_000;
    n_errors++;
    print_verdict();
  end
endmodule : serial_hold_and_sector_map_tb

// ===== serial_hold_pkg.sv
// Shared constants and types for the serial hold and sector map block
package serial_hold_pkg;
  localparam int          ADDR_W          = 24;
  localparam int          SYNC_STAGES     = 2;
  localparam int          CFG_QUAD_BIT    = 1;
  localparam int          CFG_PARAM_TOP   = 2;
  localparam int          PAGE_BYTES      = 256;
  localparam int          SECTOR_COUNT    = 128;
  localparam int          SUB_COUNT       = 32;
  localparam logic [23:0] SECTOR_LAST_OFS = 24'h00_FFFF;
  localparam logic [23:0] SUB_LAST_OFS    = 24'h00_0FFF;
  localparam logic [23:0] PAIR_LAST_OFS   = 24'h00_1FFF;
  localparam logic [23:0] ARRAY_FIRST     = 24'h00_0000;
  localparam logic [23:0] ARRAY_LAST      = 24'h7F_FFFF;
  localparam logic [23:0] SUB_BOT_LAST    = 24'h01_FFFF;
  localparam logic [23:0] SUB_TOP_FIRST   = 24'h7E_0000;
  localparam logic [5:0]  SUB_BOT_PAIR    = 6'h00;
  localparam logic [5:0]  SUB_TOP_PAIR    = 6'h3F;
  localparam logic [7:0]  ERASED_BYTE     = 8'hFF;
  localparam logic [2:0]  BIT_CNT_RST     = 3'h0;
  localparam logic [2:0]  BIT_CNT_LAST    = 3'h7;

  typedef enum logic [1:0] {
    ERASE_4K,
    ERASE_8K,
    ERASE_64K,
    ERASE_WHOLE
  } erase_kind_e;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic hold_n;
  } spi_pins_s;
endpackage : serial_hold_pkg
